// *** pmfs_pkg.sv ***
// constants, field positions and carrier types of the power fault status bank
package pmfs_pkg;

  // command codes of the status registers
  localparam logic [7:0] CMD_SUMMARY_BYTE = 8'h78;
  localparam logic [7:0] CMD_SUMMARY_WORD = 8'h79;
  localparam logic [7:0] CMD_VOUT_STATUS = 8'h7A;
  localparam logic [7:0] CMD_IOUT_STATUS = 8'h7B;
  localparam logic [7:0] CMD_INPUT_STATUS = 8'h7C;
  localparam logic [7:0] PAGE_ONLY = 8'h00;

  // summary word bit positions
  localparam int SW_VOUT = 15;
  localparam int SW_IOUT = 14;
  localparam int SW_INPUT = 13;
  localparam int SW_MFR = 12;
  localparam int SW_PGOOD_N = 11;
  localparam int SW_UNKNOWN = 8;
  localparam int SW_BUSY = 7;
  localparam int SW_OFF = 6;
  localparam int SW_VOUT_OV = 5;
  localparam int SW_IOUT_OC = 4;
  localparam int SW_VIN_UV = 3;
  localparam int SW_TEMP = 2;
  localparam int SW_CML = 1;
  localparam int SW_OTHER = 0;

  // detail byte bit positions
  localparam int VO_OV = 7;
  localparam int VO_UV = 4;
  localparam int VO_MAX = 3;
  localparam int IO_OC = 7;
  localparam int IO_UC = 4;
  localparam int IN_OV_F = 7;
  localparam int IN_OV_W = 6;
  localparam int IN_UV_W = 5;
  localparam int IN_UV_F = 4;
  localparam int IN_OFF = 3;
  localparam int IN_OC_F = 2;
  localparam int IN_OC_W = 1;

  // read path latency and values after reset
  localparam int RD_LATENCY = 1;
  localparam logic [15:0] RD_DATA_RST = 16'h0000;
  localparam int NUM_EVENTS = 15;

  // one-cycle event pulses from the core; each sets a sticky flag
  typedef struct packed {
    logic vout_ov;
    logic vout_uv;
    logic vout_max;
    logic iout_oc;
    logic iout_uc;
    logic vin_ov_f;
    logic vin_ov_w;
    logic vin_uv_w;
    logic vin_uv_f;
    logic vin_off;
    logic iin_oc_f;
    logic iin_oc_w;
    logic busy;
    logic unknown;
    logic other;
  } pmfs_events_t;

  // live levels and summaries kept by other blocks
  typedef struct packed {
    logic out_off;
    logic power_good;
    logic temp_any;
    logic cml_any;
    logic mfr_any;
  } pmfs_levels_t;

endpackage

// *** pmfs_sticky.sv ***
// sticky flag array: set by pulse, cleared by pulse, set wins
`timescale 1ns/1ps
module pmfs_sticky #(
  parameter int W = 8
) (
  input wire logic SYS_CLK, // core clock
  input wire logic RST, // synchronous reset, active high
  input wire logic [W-1:0] SET, // event pulses
  input wire logic CLR, // clear all flags
  output logic [W-1:0] Q // sticky flags
);

  // one flop per flag; an event in the clear cycle survives
  for (genvar i = 0; i < W; i++) begin : g_flag
    logic flag_ff;
    wire nxt_flag = SET[i] | (flag_ff & ~CLR);
    always_ff @(posedge SYS_CLK) begin
      if (RST) begin
        flag_ff <= 1'b0;
      end else begin
        flag_ff <= nxt_flag;
      end
    end
    assign Q[i] = flag_ff;
  end

endmodule

// *** pmfs_status_bank.sv ***
// power fault status bank: sticky fault flags and status command reads
`timescale 1ns/1ps
module pmfs_status_bank (
  input wire logic SYS_CLK, // core clock, 100 MHz
  input wire logic RST, // synchronous reset, active high
  input wire pmfs_pkg::pmfs_events_t EVT, // event pulses from the core
  input wire pmfs_pkg::pmfs_levels_t LVL, // live status levels
  input wire logic CLEAR_FAULTS, // pulse: clear all sticky flags
  input wire logic [7:0] PAGE_SEL, // currently selected page
  input wire logic CMD_RD, // pulse: read command
  input wire logic CMD_WR, // pulse: write attempt
  input wire logic [7:0] CMD_CODE, // command code of the access
  output logic [15:0] RD_DATA, // read answer, low bits for byte reads
  output logic RD_VALID, // pulse: answer valid
  output logic CMD_ERR // pulse: access refused
);

  logic [pmfs_pkg::NUM_EVENTS-1:0] sticky;
  pmfs_pkg::pmfs_events_t flg;
  logic [15:0] rd_data_ff;
  logic rd_valid_ff;
  logic cmd_err_ff;

  // flags hold until cleared so the host can read summary then detail
  pmfs_sticky #(
    .W(pmfs_pkg::NUM_EVENTS)
  ) u_sticky (
    .SYS_CLK(SYS_CLK),
    .RST(RST),
    .SET(EVT),
    .CLR(CLEAR_FAULTS),
    .Q(sticky)
  );
  assign flg = pmfs_pkg::pmfs_events_t'(sticky);

  // detail bytes; unsupported and reserved positions stay zero
  wire [7:0] vout_byte = (8'(flg.vout_ov) << pmfs_pkg::VO_OV)
    | (8'(flg.vout_uv) << pmfs_pkg::VO_UV)
    | (8'(flg.vout_max) << pmfs_pkg::VO_MAX);
  wire [7:0] iout_byte = (8'(flg.iout_oc) << pmfs_pkg::IO_OC)
    | (8'(flg.iout_uc) << pmfs_pkg::IO_UC);
  wire [7:0] input_byte = (8'(flg.vin_ov_f) << pmfs_pkg::IN_OV_F)
    | (8'(flg.vin_ov_w) << pmfs_pkg::IN_OV_W)
    | (8'(flg.vin_uv_w) << pmfs_pkg::IN_UV_W)
    | (8'(flg.vin_uv_f) << pmfs_pkg::IN_UV_F)
    | (8'(flg.vin_off) << pmfs_pkg::IN_OFF)
    | (8'(flg.iin_oc_f) << pmfs_pkg::IN_OC_F)
    | (8'(flg.iin_oc_w) << pmfs_pkg::IN_OC_W);

  // summary bits; the group bits are the OR of their detail bytes
  wire sum_vout = |vout_byte;
  wire sum_iout = |iout_byte;
  wire sum_input = |input_byte;
  wire [7:0] summary_byte = (8'(flg.busy) << pmfs_pkg::SW_BUSY)
    | (8'(LVL.out_off) << pmfs_pkg::SW_OFF)
    | (8'(flg.vout_ov) << pmfs_pkg::SW_VOUT_OV)
    | (8'(flg.iout_oc) << pmfs_pkg::SW_IOUT_OC)
    | (8'(flg.vin_uv_f) << pmfs_pkg::SW_VIN_UV)
    | (8'(LVL.temp_any) << pmfs_pkg::SW_TEMP)
    | (8'(LVL.cml_any) << pmfs_pkg::SW_CML)
    | (8'(flg.other) << pmfs_pkg::SW_OTHER);
  wire [15:0] summary_word = (16'(sum_vout) << pmfs_pkg::SW_VOUT)
    | (16'(sum_iout) << pmfs_pkg::SW_IOUT)
    | (16'(sum_input) << pmfs_pkg::SW_INPUT)
    | (16'(LVL.mfr_any) << pmfs_pkg::SW_MFR)
    | (16'(!LVL.power_good) << pmfs_pkg::SW_PGOOD_N)
    | (16'(flg.unknown) << pmfs_pkg::SW_UNKNOWN)
    | {8'h00, summary_byte};

  // command decode; only page zero exists, reads on other pages are refused
  wire page_ok = (PAGE_SEL == pmfs_pkg::PAGE_ONLY);
  wire hit_byte = (CMD_CODE == pmfs_pkg::CMD_SUMMARY_BYTE);
  wire hit_word = (CMD_CODE == pmfs_pkg::CMD_SUMMARY_WORD);
  wire hit_vout = (CMD_CODE == pmfs_pkg::CMD_VOUT_STATUS);
  wire hit_iout = (CMD_CODE == pmfs_pkg::CMD_IOUT_STATUS);
  wire hit_input = (CMD_CODE == pmfs_pkg::CMD_INPUT_STATUS);
  wire hit_any = hit_byte | hit_word | hit_vout | hit_iout | hit_input;
  wire rd_ok = CMD_RD & hit_any & page_ok;
  // a write to any of these read-only codes changes nothing and is refused
  wire wr_bad = CMD_WR & hit_any;
  wire rd_bad = CMD_RD & ~(hit_any & page_ok);
  wire [15:0] sel_data = hit_word ? summary_word
    : hit_byte ? {8'h00, summary_byte}
    : hit_vout ? {8'h00, vout_byte}
    : hit_iout ? {8'h00, iout_byte}
    : hit_input ? {8'h00, input_byte}
    : pmfs_pkg::RD_DATA_RST;
  wire [15:0] nxt_rd_data = rd_ok ? sel_data : rd_data_ff;
  wire nxt_cmd_err = rd_bad | wr_bad;

  // answer registers; data holds between reads so a slow host is safe
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      rd_data_ff <= pmfs_pkg::RD_DATA_RST;
      rd_valid_ff <= 1'b0;
      cmd_err_ff <= 1'b0;
    end else begin
      rd_data_ff <= nxt_rd_data;
      rd_valid_ff <= rd_ok;
      cmd_err_ff <= nxt_cmd_err;
    end
  end

  assign RD_DATA = rd_data_ff;
  assign RD_VALID = rd_valid_ff;
  assign CMD_ERR = cmd_err_ff;

  // word read returns the summary byte in its low half
  AST_WORD_LOW_IS_BYTE: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    summary_word[7:0] == summary_byte && summary_word[10:9] == 2'b00)
    else $error("summary word low byte differs from summary byte");

  // an output voltage event shows in bit 15 on the next cycle
  AST_VOUT_GROUP: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (EVT.vout_uv | EVT.vout_max) |=> summary_word[pmfs_pkg::SW_VOUT])
    else $error("output voltage event not seen in summary bit 15");

  // output current fault reaches bit 14 and bit 4
  AST_IOUT_GROUP: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    EVT.iout_oc |=> summary_word[pmfs_pkg::SW_IOUT] && summary_word[pmfs_pkg::SW_IOUT_OC])
    else $error("output current fault not seen in summary");

  // input events reach bit 13
  AST_INPUT_GROUP: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (EVT.vin_ov_w | EVT.iin_oc_w | EVT.vin_off) |=> summary_word[pmfs_pkg::SW_INPUT])
    else $error("input event not seen in summary bit 13");

  // power-good low reads as bit 11 set
  AST_PGOOD_N: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    summary_word[pmfs_pkg::SW_PGOOD_N] == !LVL.power_good)
    else $error("summary bit 11 does not track power good");

  // a word read answers one cycle later with the word as it stood
  AST_READ_WORD: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (CMD_RD && hit_word && page_ok) |=> RD_VALID && RD_DATA == $past(summary_word))
    else $error("word read answer wrong or late");

  // busy event sticks until cleared, and survives a clear in the same cycle
  AST_BUSY_STICKS: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    EVT.busy ##1 !CLEAR_FAULTS [*2] |-> summary_byte[pmfs_pkg::SW_BUSY])
    else $error("busy flag lost before a clear");

  // off level appears directly in bit 6
  AST_OFF_BIT: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    summary_byte[pmfs_pkg::SW_OFF] == LVL.out_off)
    else $error("summary bit 6 does not follow output off");

  // detail byte reads keep unsupported positions at zero
  AST_VOUT_RESERVED: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (CMD_RD && hit_vout && page_ok) |=> RD_DATA[15:8] == 8'h00 && RD_DATA[6:5] == 2'b00
      && RD_DATA[2:0] == 3'h0)
    else $error("unsupported output voltage bits read nonzero");

  // writes to the status codes are refused and leave the flags untouched
  AST_WRITE_IGNORED: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (CMD_WR && hit_any && !CLEAR_FAULTS) |=> CMD_ERR && sticky == ($past(sticky) | $past(EVT)))
    else $error("write to read-only status was not ignored");

  // current detail bits feed the group bit exactly
  AST_IOUT_OR: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    summary_word[pmfs_pkg::SW_IOUT] == (flg.iout_oc | flg.iout_uc))
    else $error("summary bit 14 is not the OR of its detail byte");

  // a read on a page other than zero is refused with no data
  AST_PAGE_REFUSED: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (CMD_RD && !page_ok) |=> CMD_ERR && !RD_VALID)
    else $error("read on a nonzero page was not refused");

  // output overvoltage lands in the detail byte and in summary bit 5
  AST_VOUT_OV_SET: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    EVT.vout_ov |=> vout_byte[pmfs_pkg::VO_OV] && summary_byte[pmfs_pkg::SW_VOUT_OV])
    else $error("output overvoltage event not flagged");

  // output undervoltage lands in detail bit 4
  AST_VOUT_UV_SET: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    EVT.vout_uv |=> vout_byte[pmfs_pkg::VO_UV])
    else $error("output undervoltage event not flagged");

  // maximum output voltage warning lands in detail bit 3
  AST_VOUT_MAX_SET: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    EVT.vout_max |=> vout_byte[pmfs_pkg::VO_MAX])
    else $error("output voltage maximum warning not flagged");

  // undercurrent lands in detail bit 4 and raises the current group bit
  AST_IOUT_UC_SET: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    EVT.iout_uc |=> iout_byte[pmfs_pkg::IO_UC] && summary_word[pmfs_pkg::SW_IOUT])
    else $error("output undercurrent event not flagged");

  // input undervoltage fault lands in the detail byte and in summary bit 3
  AST_VIN_UV_SET: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    EVT.vin_uv_f |=> input_byte[pmfs_pkg::IN_UV_F] && summary_byte[pmfs_pkg::SW_VIN_UV])
    else $error("input undervoltage fault not flagged");

  // input overvoltage warning lands in detail bit 6
  AST_VIN_OV_WARN_SET: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    EVT.vin_ov_w |=> input_byte[pmfs_pkg::IN_OV_W])
    else $error("input overvoltage warning not flagged");

  // input undervoltage warning lands in detail bit 5
  AST_VIN_UV_WARN_SET: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    EVT.vin_uv_w |=> input_byte[pmfs_pkg::IN_UV_W])
    else $error("input undervoltage warning not flagged");

  // shutdown for low input lands in detail bit 3
  AST_VIN_OFF_SET: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    EVT.vin_off |=> input_byte[pmfs_pkg::IN_OFF])
    else $error("low input shutdown not flagged");

  // input overcurrent fault lands in detail bit 2
  AST_IIN_OC_FAULT_SET: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    EVT.iin_oc_f |=> input_byte[pmfs_pkg::IN_OC_F])
    else $error("input overcurrent fault not flagged");

  // input overcurrent warning lands in detail bit 1
  AST_IIN_OC_WARN_SET: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    EVT.iin_oc_w |=> input_byte[pmfs_pkg::IN_OC_W])
    else $error("input overcurrent warning not flagged");

  // vendor summary is a live level, not latched here
  AST_MFR_BIT: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    summary_word[pmfs_pkg::SW_MFR] == LVL.mfr_any)
    else $error("summary bit 12 does not follow vendor status");

  // an uncovered fault sets bit 8 on the next cycle
  AST_UNKNOWN_SET: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    EVT.unknown |=> summary_word[pmfs_pkg::SW_UNKNOWN])
    else $error("uncovered fault not seen in summary bit 8");

  // temperature and comms summaries come straight from their owners
  AST_TEMP_CML: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    summary_byte[pmfs_pkg::SW_TEMP] == LVL.temp_any
      && summary_byte[pmfs_pkg::SW_CML] == LVL.cml_any)
    else $error("summary bits 2 or 1 do not follow their levels");

  // any other status change sets bit 0 on the next cycle
  AST_OTHER_SET: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    EVT.other |=> summary_byte[pmfs_pkg::SW_OTHER])
    else $error("other status change not seen in summary bit 0");

  // an event in the clear cycle must not be lost
  AST_SET_BEATS_CLEAR: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (EVT.busy && CLEAR_FAULTS) |=> summary_byte[pmfs_pkg::SW_BUSY])
    else $error("busy event lost to a same-cycle clear");

  // voltage group bit is exactly the OR of its detail flags
  AST_VOUT_OR: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    summary_word[pmfs_pkg::SW_VOUT] == (flg.vout_ov | flg.vout_uv | flg.vout_max))
    else $error("summary bit 15 is not the OR of its detail byte");

  // input group bit is exactly the OR of its detail flags
  AST_INPUT_OR: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    summary_word[pmfs_pkg::SW_INPUT] == (flg.vin_ov_f | flg.vin_ov_w | flg.vin_uv_w
      | flg.vin_uv_f | flg.vin_off | flg.iin_oc_f | flg.iin_oc_w))
    else $error("summary bit 13 is not the OR of its detail byte");

  // a byte read answers with the summary byte and a clear high half
  AST_READ_BYTE: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (CMD_RD && hit_byte && page_ok) |=> RD_VALID && RD_DATA == {8'h00, $past(summary_byte)})
    else $error("summary byte read answer wrong or late");

  // a voltage detail read answers with the byte as it stood
  AST_READ_VOUT: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (CMD_RD && hit_vout && page_ok) |=> RD_VALID && RD_DATA == {8'h00, $past(vout_byte)})
    else $error("output voltage read answer wrong or late");

  // a current detail read answers with the byte, reserved bits 6:5 and 3:0 clear
  AST_READ_IOUT: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (CMD_RD && hit_iout && page_ok) |=> RD_VALID && RD_DATA == {8'h00, $past(iout_byte)}
      && RD_DATA[6:5] == 2'b00 && RD_DATA[3:0] == 4'h0)
    else $error("output current read answer wrong or late");

  // an input detail read answers with the byte, bit 0 clear
  AST_READ_INPUT: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (CMD_RD && hit_input && page_ok) |=> RD_VALID && RD_DATA == {8'h00, $past(input_byte)}
      && RD_DATA[0] == 1'b0)
    else $error("input status read answer wrong or late");

  // a write alone never disturbs the standing answer
  AST_WRITE_KEEPS_DATA: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (CMD_WR && !CMD_RD) |=> $stable(RD_DATA) && !RD_VALID)
    else $error("write changed the read answer");

  // a refused read leaves the last good answer standing
  AST_REFUSED_KEEPS_DATA: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (CMD_RD && !(hit_any && page_ok)) |=> $stable(RD_DATA) && !RD_VALID && CMD_ERR)
    else $error("refused read changed the answer or was not flagged");

endmodule

// *** pmfs_host_model.sv ***
// host controller model driving the status command port
`timescale 1ns/1ps
module pmfs_host_model (
  input wire logic SYS_CLK, // core clock
  input wire logic [15:0] RD_DATA, // read answer
  input wire logic RD_VALID, // answer valid
  input wire logic CMD_ERR, // access refused
  output logic CMD_RD, // read request
  output logic CMD_WR, // write attempt
  output logic [7:0] CMD_CODE, // command code
  output logic [7:0] PAGE_SEL // selected page
);
  // idle until asked; only one page exists, so it is chosen up front
  initial begin
    CMD_RD = 1'b0;
    CMD_WR = 1'b0;
    CMD_CODE = 8'hFF;
    PAGE_SEL = 8'h00;
  end

  // one access: request for one cycle, answer looked at in the cycle after
  task automatic access(input logic wr, input logic [7:0] code, input logic [7:0] page,
                        output logic [15:0] d, output logic v, output logic e);
    @(posedge SYS_CLK);
    CMD_RD <= ~wr;
    CMD_WR <= wr;
    CMD_CODE <= code;
    PAGE_SEL <= page;
    @(posedge SYS_CLK);
    CMD_RD <= 1'b0;
    CMD_WR <= 1'b0;
    CMD_CODE <= ~code; // released code is not left showing the old value
    @(negedge SYS_CLK);
    d = RD_DATA;
    v = RD_VALID;
    e = CMD_ERR;
  endtask
endmodule

// *** pmfs_status_bank_tb_top.sv ***
// self-checking bench of the power fault status bank
`timescale 1ns/1ps
module pmfs_status_bank_tb_top;
  logic sys_clk, rst, clear_faults, run, cmd_rd, cmd_wr, rd_valid, cmd_err, v, e;
  pmfs_pkg::pmfs_events_t evt, st, last_st;
  pmfs_pkg::pmfs_levels_t lvl, last_lvl;
  logic [7:0] cmd_code, page_sel;
  logic [15:0] rd_data, good, d;
  logic [31:0] lfsr;
  int n_mismatch, samples_checked;

  pmfs_status_bank u_pmfs_status_bank (.SYS_CLK(sys_clk), .RST(rst), .EVT(evt), .LVL(lvl),
    .CLEAR_FAULTS(clear_faults), .PAGE_SEL(page_sel), .CMD_RD(cmd_rd), .CMD_WR(cmd_wr),
    .CMD_CODE(cmd_code), .RD_DATA(rd_data), .RD_VALID(rd_valid), .CMD_ERR(cmd_err));
  pmfs_host_model u_pmfs_host_model (.SYS_CLK(sys_clk), .RD_DATA(rd_data), .RD_VALID(rd_valid),
    .CMD_ERR(cmd_err), .CMD_RD(cmd_rd), .CMD_WR(cmd_wr), .CMD_CODE(cmd_code),
    .PAGE_SEL(page_sel));

  function automatic logic [31:0] nxt_rand(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // expected answer of a status read from flag and level snapshots
  function automatic logic [15:0] exp_of(input logic [7:0] code,
                                        input pmfs_pkg::pmfs_events_t s,
                                        input pmfs_pkg::pmfs_levels_t l);
    logic [7:0] vo, io, vi;
    vo = {s.vout_ov, 2'h0, s.vout_uv, s.vout_max, 3'h0};
    io = {s.iout_oc, 2'h0, s.iout_uc, 4'h0};
    vi = {s.vin_ov_f, s.vin_ov_w, s.vin_uv_w, s.vin_uv_f, s.vin_off, s.iin_oc_f, s.iin_oc_w, 1'h0};
    case (code)
      8'h79: return {|vo, |io, |vi, l.mfr_any, ~l.power_good, 2'h0, s.unknown, s.busy, l.out_off,
                     s.vout_ov, s.iout_oc, s.vin_uv_f, l.temp_any, l.cml_any, s.other};
      8'h78: return {8'h00, s.busy, l.out_off, s.vout_ov, s.iout_oc, s.vin_uv_f, l.temp_any,
                     l.cml_any, s.other};
      8'h7A: return {8'h00, vo};
      8'h7B: return {8'h00, io};
      default: return {8'h00, vi};
    endcase
  endfunction

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one access; refused reads and all writes must leave the last answer standing
  task automatic op(input logic wr, input logic [7:0] code, input logic [7:0] page);
    logic stat;
    logic ok;
    u_pmfs_host_model.access(wr, code, page, d, v, e);
    stat = (code >= 8'h78) && (code <= 8'h7C);
    ok = stat && (page == 8'h00);
    if (!wr && ok) good = exp_of(code, last_st, last_lvl);
    check("valid", {15'h0, !wr && ok}, {15'h0, v});
    check("refusal", {15'h0, wr ? stat : !ok}, {15'h0, e});
    check("data", good, d);
  endtask

  task automatic close_out();
    if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // random stimulus plus the flag model; a read sees flags set before its edge
  always @(posedge sys_clk) begin
    last_st = st;
    last_lvl = lvl;
    if (rst) st = '0;
    else st = (clear_faults ? '0 : st) | evt; // set beats a same-cycle clear
    lfsr = nxt_rand(nxt_rand(lfsr));
    evt <= run ? pmfs_pkg::pmfs_events_t'(lfsr[14:0] & lfsr[29:15] & {15{lfsr[30]}}) : '0;
    lvl <= run ? pmfs_pkg::pmfs_levels_t'(lfsr[20:16]) : '0;
    clear_faults <= run && (lfsr[31:29] == 3'h0);
  end

  // cuts a hang short well past the expected run length
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    close_out();
  end

  initial begin
    rst = 1'b1;
    run = 1'b0;
    evt = '0;
    lvl = '0;
    clear_faults = 1'b0;
    lfsr = 32'h1FF9;
    good = 16'h0000;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    check("reset data", pmfs_pkg::RD_DATA_RST, rd_data);
    check("reset flags", 16'h0000, {14'h0000, rd_valid, cmd_err});
    run = 1'b1;
    for (int i = 0; i < 400; i++) begin
      op(i % 7 == 3, 8'h76 + 8'(i % 8), (i % 11 == 5) ? 8'h01 : 8'h00);
    end
    close_out();
  end
endmodule
